// [shared/acgc_pkg.sv]
// Constants, types and codec settings for the audio codec gain configurator
package acgc_pkg;
   // Clock and timing
   localparam int ACGC_CLK_MHZ        = 25;
   localparam int ACGC_I2C_QUARTER_NS = 2500;
   localparam int ACGC_QUARTER_CYC    = (ACGC_I2C_QUARTER_NS * ACGC_CLK_MHZ + 999) / 1000;
   localparam int ACGC_DEBOUNCE_MS    = 10;
   localparam int ACGC_DEBOUNCE_CYC   = ACGC_DEBOUNCE_MS * ACGC_CLK_MHZ * 1000;

   // Volume stepping
   localparam int       ACGC_VOL_LEVELS = 10;
   localparam logic [3:0] ACGC_VOL_MAX  = 4'h9;
   localparam logic [6:0] ACGC_VOL_BASE = 7'h2F;
   localparam logic [6:0] ACGC_VOL_STEP = 7'h06;

   // Bus framing: address byte, two data bytes, each followed by an ack slot
   localparam logic [6:0] ACGC_DEV_ADDR   = 7'h1A;
   localparam logic [4:0] ACGC_FRAME_LAST = 5'h1A;
   localparam logic [4:0] ACGC_ACK_SLOT0  = 5'h08;
   localparam logic [4:0] ACGC_ACK_SLOT1  = 5'h11;

   // Codec register addresses and values
   localparam logic [6:0] ACGC_REG_RESET  = 7'h0F;
   localparam logic [6:0] ACGC_REG_PATH   = 7'h04;
   localparam logic [6:0] ACGC_REG_POWER  = 7'h06;
   localparam logic [6:0] ACGC_REG_FORMAT = 7'h07;
   localparam logic [6:0] ACGC_REG_RATE   = 7'h08;
   localparam logic [6:0] ACGC_REG_ACTIVE = 7'h09;
   localparam logic [6:0] ACGC_REG_GAIN   = 7'h02;
   localparam int         ACGC_PATH_BYPASS_BIT = 3;
   localparam int         ACGC_PATH_MONITOR_BIT = 5;
   localparam logic [8:0] ACGC_PATH_VAL   = 9'h029;
   localparam logic [8:0] ACGC_POWER_VAL  = 9'h000;
   localparam logic [8:0] ACGC_FORMAT_VAL = 9'h042;
   localparam logic [8:0] ACGC_RATE_48K   = 9'h000;
   localparam logic [8:0] ACGC_ACTIVE_VAL = 9'h001;
   localparam logic [8:0] ACGC_GAIN_BOTH  = 9'h100;

   // Init sequence entry numbers
   localparam logic [2:0] ACGC_E_RESET = 3'h0;
   localparam logic [2:0] ACGC_E_PATH  = 3'h1;
   localparam logic [2:0] ACGC_E_POWER = 3'h2;
   localparam logic [2:0] ACGC_E_FMT   = 3'h3;
   localparam logic [2:0] ACGC_E_RATE  = 3'h4;
   localparam logic [2:0] ACGC_E_ACT   = 3'h5;
   localparam logic [2:0] ACGC_E_GAIN  = 3'h6;

   typedef enum logic [2:0] {
      ACGC_IDLE  = 3'h0,
      ACGC_START = 3'h1,
      ACGC_BIT   = 3'h2,
      ACGC_STOP  = 3'h3
   } acgc_state_t;

   typedef struct packed {
      logic [6:0] reg_addr;
      logic [8:0] data;
   } acgc_word_t;

   typedef struct packed {
      logic scl_oe;
      logic sda_oe;
   } acgc_drive_t;
endpackage

// [logic/acgc_config.sv]
// Audio codec configurator: I2C setup writes and pushbutton volume stepping
//
// Functional notes
// - Configure codec over I2C writes
// - Configure 48 kHz for both converters
// - A press rewrites codec gain over I2C; presses made while a write runs share one rewrite
// - Volume index 0..9, wraps 9 to 0
// - Enable bypass and mic monitor paths
`timescale 1ns/100ps
module acgc_config #(
   parameter int DEBOUNCE_CYC = acgc_pkg::ACGC_DEBOUNCE_CYC
) (
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   input  wire logic       i_volume_step_button_n,
   input  wire logic       i_serial_bit_clock,
   input  wire logic       i_channel_select_clock,
   input  wire logic       i_scl_in,
   input  wire logic       i_sda_in,
   output logic            o_scl_out,
   output logic            o_scl_oe,
   output logic            o_sda_out,
   output logic            o_sda_oe,
   output logic [3:0]      o_volume_index,
   output logic            o_config_done,
   output logic            o_busy,
   output logic            o_nack_seen,
   output logic            o_codec_clocks_live
);
   localparam int DW = $clog2(DEBOUNCE_CYC + 1);
   localparam logic [DW-1:0] DEB_LAST = DW'(DEBOUNCE_CYC - 1);
   localparam logic [6:0] Q_LAST = 7'(acgc_pkg::ACGC_QUARTER_CYC - 1);
   // Idle levels: button released high, codec clocks low until they start (no false edge)
   localparam logic [2:0] SYNC_IDLE = 3'h4;

   // Codec word for each sequence entry; the gain entry follows the volume
   function automatic acgc_pkg::acgc_word_t cfg_word(input logic [2:0] e, input logic [3:0] v);
      acgc_pkg::acgc_word_t w;
      logic [8:0]           g;
      g = 9'({3'h0, v} * acgc_pkg::ACGC_VOL_STEP + acgc_pkg::ACGC_VOL_BASE);
      w = '{acgc_pkg::ACGC_REG_GAIN, acgc_pkg::ACGC_GAIN_BOTH | g};
      case (e)
         acgc_pkg::ACGC_E_RESET: w = '{acgc_pkg::ACGC_REG_RESET, 9'h000};
         acgc_pkg::ACGC_E_PATH:  w = '{acgc_pkg::ACGC_REG_PATH, acgc_pkg::ACGC_PATH_VAL};
         acgc_pkg::ACGC_E_POWER: w = '{acgc_pkg::ACGC_REG_POWER, acgc_pkg::ACGC_POWER_VAL};
         acgc_pkg::ACGC_E_FMT:   w = '{acgc_pkg::ACGC_REG_FORMAT, acgc_pkg::ACGC_FORMAT_VAL};
         acgc_pkg::ACGC_E_RATE:  w = '{acgc_pkg::ACGC_REG_RATE, acgc_pkg::ACGC_RATE_48K};
         acgc_pkg::ACGC_E_ACT:   w = '{acgc_pkg::ACGC_REG_ACTIVE, acgc_pkg::ACGC_ACTIVE_VAL};
         default: ;
      endcase
      return w;
   endfunction

   logic [2:0]           sync1_q, sync2_q;
   logic [1:0]           clk_prev_q;
   logic                 bck_seen_q, live_q;
   logic [DW-1:0]        deb_cnt_q;
   logic                 stable_q, press_q;
   logic [3:0]           vol_q;
   logic                 vol_pending_q;
   logic [2:0]           entry_q;
   logic                 init_done_q;
   acgc_pkg::acgc_state_t state_q, state_d;
   logic [6:0]           qcnt_q;
   logic [1:0]           phase_q;
   logic [4:0]           bit_q;
   logic [26:0]          frame_q;
   logic                 nack_q;
   acgc_pkg::acgc_drive_t drv_q, drv_d;
   logic                 sda_s1_q, sda_s2_q;

   // Button, codec clocks and SDA each pass two flip-flops
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         sync1_q <= SYNC_IDLE;
         sync2_q <= SYNC_IDLE;
      end else begin
         sync1_q <= {i_volume_step_button_n, i_serial_bit_clock, i_channel_select_clock};
         sync2_q <= sync1_q;
      end
   end

   // Codec clocks are only observed; the codec is their master
   wire bck_rise = sync2_q[1] & ~clk_prev_q[1];
   wire channel_select_clock_rise = sync2_q[0] & ~clk_prev_q[0];
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         clk_prev_q <= 2'h0;
         bck_seen_q <= 1'b0;
         live_q     <= 1'b0;
      end else begin
         clk_prev_q <= sync2_q[1:0];
         bck_seen_q <= bck_seen_q | bck_rise;
         live_q     <= live_q | (bck_seen_q & channel_select_clock_rise);
      end
   end

   // Debounce: level must hold for the full count before it is accepted
   wire btn_diff  = sync2_q[2] ^ stable_q;
   wire deb_fire  = btn_diff && (deb_cnt_q == DEB_LAST);
   wire press_d   = deb_fire & ~sync2_q[2];
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         deb_cnt_q <= '0;
         stable_q  <= 1'b1;
         press_q   <= 1'b0;
      end else begin
         deb_cnt_q <= (btn_diff && !deb_fire) ? deb_cnt_q + 1'b1 : '0;
         stable_q  <= deb_fire ? sync2_q[2] : stable_q;
         press_q   <= press_d;
      end
   end

   // Volume index and pending gain rewrite; a new press wins over the clear
   wire engine_idle = (state_q == acgc_pkg::ACGC_IDLE);
   wire launch_init = engine_idle & ~init_done_q;
   wire launch_vol  = engine_idle & init_done_q & vol_pending_q;
   wire launch      = launch_init | launch_vol;
   wire [3:0] vol_d = (vol_q == acgc_pkg::ACGC_VOL_MAX) ? 4'h0 : vol_q + 4'h1;
   wire [2:0] load_entry = launch_init ? entry_q : acgc_pkg::ACGC_E_GAIN;
   acgc_pkg::acgc_word_t load_word;
   assign load_word = cfg_word(load_entry, vol_q);
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         vol_q         <= 4'h0;
         vol_pending_q <= 1'b0;
      end else begin
         vol_q         <= press_q ? vol_d : vol_q;
         vol_pending_q <= press_q | (vol_pending_q & ~launch_vol);
      end
   end

   // Quarter-bit timing and bit-level sequencing
   wire tick      = (qcnt_q == Q_LAST);
   wire end_slot  = tick && (phase_q == 2'h3);
   wire ack_slot  = (bit_q == acgc_pkg::ACGC_ACK_SLOT0) || (bit_q == acgc_pkg::ACGC_ACK_SLOT1)
                    || (bit_q == acgc_pkg::ACGC_FRAME_LAST);
   wire frame_end = end_slot && (state_q == acgc_pkg::ACGC_STOP);
   always_comb begin
      state_d = state_q;
      drv_d   = '{1'b0, 1'b0};
      case (state_q)
         acgc_pkg::ACGC_IDLE: begin
            if (launch) state_d = acgc_pkg::ACGC_START;
         end
         acgc_pkg::ACGC_START: begin
            drv_d = '{phase_q == 2'h3, phase_q != 2'h0};
            if (end_slot) state_d = acgc_pkg::ACGC_BIT;
         end
         acgc_pkg::ACGC_BIT: begin
            drv_d = '{(phase_q == 2'h0) || (phase_q == 2'h3), ~frame_q[26]};
            if (end_slot && bit_q == acgc_pkg::ACGC_FRAME_LAST) state_d = acgc_pkg::ACGC_STOP;
         end
         acgc_pkg::ACGC_STOP: begin
            drv_d = '{phase_q == 2'h0, phase_q != 2'h3};
            if (end_slot) state_d = acgc_pkg::ACGC_IDLE;
         end
         default: state_d = acgc_pkg::ACGC_IDLE;
      endcase
   end

   // Bus engine registers: frame shifter, slot counters, ack check
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= acgc_pkg::ACGC_IDLE;
         qcnt_q  <= 7'h00;
         phase_q <= 2'h0;
         bit_q   <= 5'h00;
         frame_q <= 27'h000_0000;
         nack_q  <= 1'b0;
         drv_q   <= '{1'b0, 1'b0};
      end else begin
         state_q <= state_d;
         drv_q   <= drv_d;
         qcnt_q  <= (tick || launch) ? 7'h00 : qcnt_q + 7'h01;
         phase_q <= launch ? 2'h0 : (tick ? phase_q + 2'h1 : phase_q);
         if (launch) begin
            bit_q   <= 5'h00;
            frame_q <= {acgc_pkg::ACGC_DEV_ADDR, 1'b0, 1'b1, load_word[15:8], 1'b1,
                        load_word[7:0], 1'b1};
         end else if (end_slot && state_q == acgc_pkg::ACGC_BIT) begin
            bit_q   <= bit_q + 5'h01;
            frame_q <= {frame_q[25:0], 1'b1};
         end
         if (tick && phase_q == 2'h2 && state_q == acgc_pkg::ACGC_BIT && ack_slot)
            nack_q <= nack_q | sda_s2_q;
      end
   end

   // SDA synchroniser kept apart from the shared bank
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end else begin
         sda_s1_q <= i_sda_in;
         sda_s2_q <= sda_s1_q;
      end
   end

   // Init sequence advance; gain entry is last so it carries the volume
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         entry_q     <= acgc_pkg::ACGC_E_RESET;
         init_done_q <= 1'b0;
      end else if (frame_end && !init_done_q) begin
         entry_q     <= (entry_q == acgc_pkg::ACGC_E_GAIN) ? entry_q : entry_q + 3'h1;
         init_done_q <= (entry_q == acgc_pkg::ACGC_E_GAIN);
      end
   end

   // Open-drain pins only pull low; SCL input is not used for stretching
   assign o_scl_out           = 1'b0;
   assign o_sda_out           = 1'b0;
   assign o_scl_oe            = drv_q.scl_oe;
   assign o_sda_oe            = drv_q.sda_oe;
   assign o_volume_index      = vol_q;
   assign o_config_done       = init_done_q;
   assign o_busy              = ~engine_idle;
   assign o_nack_seen         = nack_q;
   assign o_codec_clocks_live = live_q;

   // Checks
   a_vol_wrap: assert property (@(posedge i_clock) disable iff (!i_resetn)
      press_q && vol_q == acgc_pkg::ACGC_VOL_MAX |=> vol_q == 4'h0)
      else $error("volume did not wrap to zero");
   a_vol_step: assert property (@(posedge i_clock) disable iff (!i_resetn)
      !press_q |=> vol_q == $past(vol_q))
      else $error("volume moved without a press");
   a_press_single: assert property (@(posedge i_clock) disable iff (!i_resetn)
      press_q |=> !press_q [*2])
      else $error("one press gave more than one step");
   a_gain_request: assert property (@(posedge i_clock) disable iff (!i_resetn)
      press_q |=> vol_pending_q || !engine_idle)
      else $error("press did not queue a gain write");
   a_rate_word: assert property (@(posedge i_clock) disable iff (!i_resetn)
      launch_init && entry_q == acgc_pkg::ACGC_E_RATE |=>
      frame_q[8:1] == acgc_pkg::ACGC_RATE_48K[7:0] && frame_q[10] == acgc_pkg::ACGC_RATE_48K[8])
      else $error("rate word not 48 kHz");
   a_mix_path: assert property (@(posedge i_clock) disable iff (!i_resetn)
      launch_init && entry_q == acgc_pkg::ACGC_E_PATH |=>
      frame_q[1 + acgc_pkg::ACGC_PATH_BYPASS_BIT] && frame_q[1 + acgc_pkg::ACGC_PATH_MONITOR_BIT])
      else $error("bypass or monitor path not enabled");
   a_start_cond: assert property (@(posedge i_clock) disable iff (!i_resetn)
      state_q == acgc_pkg::ACGC_START && phase_q == 2'h1 |=> o_sda_oe && !o_scl_oe)
      else $error("start condition malformed");
endmodule

// [sim/acgc_codec_model.sv]
// Behavioural codec model: I2C write receiver plus master-mode audio clocks
`timescale 1ns/100ps
module acgc_codec_model (
   input  wire logic i_scl,
   input  wire logic i_sda,
   input  wire logic i_nack_mode,
   output logic      o_sda_oe,
   output logic      o_bit_clock,
   output logic      o_channel_clock
);
   logic [23:0] words[$];
   logic [23:0] shift_q;
   logic        clocks_on;
   logic        mix_on;
   int          bit_cnt;
   int          lr_cnt;
   wire logic   sda_late;

   // Delayed data view so a data change at a clock fall is not read as start or stop
   assign #1 sda_late = i_sda;

   initial begin
      o_sda_oe = 1'b0;
      o_bit_clock = 1'b0;
      o_channel_clock = 1'b0;
      clocks_on = 1'b0;
      mix_on = 1'b0;
      shift_q = '0;
      bit_cnt = 0;
      lr_cnt = 0;
   end

   // Start restarts the bit count, stop stores a whole three-byte frame
   always @(negedge sda_late) if (i_scl === 1'b1) bit_cnt = 0;
   always @(posedge sda_late) begin
      if (i_scl === 1'b1 && bit_cnt == 27) begin
         words.push_back(shift_q);
         if (shift_q[15:9] == acgc_pkg::ACGC_REG_ACTIVE && shift_q[0]) clocks_on = 1'b1;
         // Line-in and microphone are mixed once bypass and monitor paths are on
         if (shift_q[15:9] == acgc_pkg::ACGC_REG_PATH
             && shift_q[acgc_pkg::ACGC_PATH_BYPASS_BIT]
             && shift_q[acgc_pkg::ACGC_PATH_MONITOR_BIT]) mix_on = 1'b1;
      end
   end

   // Data bits taken on clock rise, ack slots skipped
   // The clock rise inside the stop condition is not a data bit
   always @(posedge i_scl) begin
      if (bit_cnt < 27) begin
         if (bit_cnt != 8 && bit_cnt != 17 && bit_cnt != 26) shift_q = {shift_q[22:0], i_sda};
         bit_cnt++;
      end
   end

   // Ack pulls data low for one slot unless told to refuse
   always @(negedge i_scl) begin
      o_sda_oe = (bit_cnt == 8 || bit_cnt == 17 || bit_cnt == 26) && !i_nack_mode;
   end

   // Master mode: codec makes both audio clocks once active, 320 ns bit clock
   always begin
      #160;
      if (clocks_on) o_bit_clock = ~o_bit_clock;
   end
   always @(negedge o_bit_clock) begin
      lr_cnt++;
      if (lr_cnt % 32 == 0) o_channel_clock = ~o_channel_clock;
   end
endmodule

// [sim/acgc_config_test.sv]
// Self-checking bench for the audio codec gain configurator
`timescale 1ns/100ps
module acgc_config_test;
   localparam int DEB  = 8;
   localparam int CEIL = 95000;
   logic       clk, rstn, btn_n, nack_mode, codec_sda_oe, bclk, lrclk;
   logic       scl_oe, sda_oe, done, busy, nack, live, scl_out, sda_out;
   logic [3:0] vol;
   int         failures, checked, cyc, base;
   wire logic  scl_line = ~scl_oe;
   wire logic  sda_line = ~(sda_oe | codec_sda_oe);

   acgc_config #(.DEBOUNCE_CYC(DEB)) i_acgc_config (
      .i_clock(clk), .i_resetn(rstn), .i_volume_step_button_n(btn_n),
      .i_serial_bit_clock(bclk), .i_channel_select_clock(lrclk),
      .i_scl_in(scl_line), .i_sda_in(sda_line),
      .o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .o_volume_index(vol), .o_config_done(done), .o_busy(busy),
      .o_nack_seen(nack), .o_codec_clocks_live(live));

   acgc_codec_model i_acgc_codec_model (
      .i_scl(scl_line), .i_sda(sda_line), .i_nack_mode(nack_mode),
      .o_sda_oe(codec_sda_oe), .o_bit_clock(bclk), .o_channel_clock(lrclk));

   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [23:0] frame(input logic [6:0] ra, input logic [8:0] d);
      return {acgc_pkg::ACGC_DEV_ADDR, 1'b0, ra, d};
   endfunction

   function automatic logic [23:0] gain(input int v);
      return frame(acgc_pkg::ACGC_REG_GAIN, acgc_pkg::ACGC_GAIN_BOTH
                   | 9'(acgc_pkg::ACGC_VOL_BASE + acgc_pkg::ACGC_VOL_STEP * v));
   endfunction

   // Bus counts as idle once busy stays low for several cycles
   task automatic wait_idle;
      int quiet;
      quiet = 0;
      while (quiet < 5) begin
         @(negedge clk);
         quiet = (busy === 1'b0) ? quiet + 1 : 0;
      end
   endtask

   // One press with a short bounce ahead of the settled level
   task automatic press;
      btn_n = 1'b0;
      repeat (3) @(negedge clk);
      btn_n = 1'b1;
      repeat (2) @(negedge clk);
      btn_n = 1'b0;
      repeat (2 * DEB + 6) @(negedge clk);
      btn_n = 1'b1;
      repeat (2 * DEB + 6) @(negedge clk);
   endtask

   task automatic test_init;
      logic [6:0] regs[7];
      logic [8:0] vals[7];
      regs = '{7'h0F, 7'h04, 7'h06, 7'h07, 7'h08, 7'h09, 7'h02};
      vals = '{9'h000, 9'h029, 9'h000, 9'h042, 9'h000, 9'h001, 9'h12F};
      wait_idle();
      check("init frames", 24'd7, 24'(i_acgc_codec_model.words.size()));
      for (int i = 0; i < 7; i++) begin
         check("init word", frame(regs[i], vals[i]), i_acgc_codec_model.words[i]);
      end
      check("rate", frame(7'h08, 9'h000), i_acgc_codec_model.words[4]);
      check("bypass", 24'd1, 24'(i_acgc_codec_model.words[1][3]));
      check("monitor", 24'd1, 24'(i_acgc_codec_model.words[1][5]));
      check("mix path", 24'd1, 24'(i_acgc_codec_model.mix_on));
      check("drive levels", 24'd0, 24'({scl_out, sda_out}));
      check("start gain", gain(0), i_acgc_codec_model.words[6]);
      check("done", 24'd1, 24'(done));
      check("nack", 24'd0, 24'(nack));
      check("clocks live", 24'd1, 24'(live));
   endtask

   // Ten quick presses: index walks up and wraps, writes coalesce behind the first
   task automatic test_wrap;
      base = i_acgc_codec_model.words.size();
      for (int i = 1; i <= 10; i++) begin
         press();
         check("volume", 24'(i % 10), 24'(vol));
      end
      wait_idle();
      check("burst frames", 24'd2, 24'(i_acgc_codec_model.words.size() - base));
      check("first gain", gain(1), i_acgc_codec_model.words[base]);
      check("last gain", gain(0), i_acgc_codec_model.words[base + 1]);
   endtask

   // Lone press gives exactly one write; a refused ack still completes the frame
   task automatic test_single(input int v, input logic refuse);
      nack_mode = refuse;
      base = i_acgc_codec_model.words.size();
      press();
      wait_idle();
      check("volume", 24'(v), 24'(vol));
      check("single frames", 24'd1, 24'(i_acgc_codec_model.words.size() - base));
      check("single gain", gain(v), i_acgc_codec_model.words[base]);
      check("nack", 24'(refuse), 24'(nack));
      nack_mode = 1'b0;
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == CEIL) begin
         failures++;
         close_out();
      end
   end

   initial begin
      rstn = 1'b0;
      btn_n = 1'b1;
      nack_mode = 1'b0;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      test_init();
      test_wrap();
      test_single(1, 1'b0);
      test_single(2, 1'b1);
      close_out();
   end
endmodule
